// ==== shared/clp_pkg.sv ====
// Shared constants and types for the cold load pick-up detector
package clp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_MS = 5;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 18;

    // Timer settings count 5 ms steps
    localparam int TIME_W = 19;
    localparam logic [18:0] START_DELAY_DEFAULT = 19'h007d0;
    localparam logic [18:0] MAX_START_DEFAULT = 19'h01770;
    localparam logic [18:0] MIN_HOLD_DEFAULT = 19'h00008;

    // ------------------------------------------------------------
    // Magnitudes in 0.01 x In steps
    // ------------------------------------------------------------
    localparam int MAG_W = 12;
    localparam logic [11:0] LOW_DEFAULT = 12'h014;
    localparam logic [11:0] HIGH_DEFAULT = 12'h078;
    localparam logic [11:0] OVER_DEFAULT = 12'h0c8;
    localparam int RESET_NUM = 97;
    localparam int RESET_DEN = 100;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {CLP_SIDE_1, CLP_SIDE_2} clp_side_type;

    typedef enum logic [2:0] {
        CLP_NORMAL,
        CLP_CURR_LOW,
        CLP_OVERCURRENT_ON,
        CLP_ACTIVE,
        CLP_BLOCKED
    } function_condition_status_type;

    typedef struct packed {
        logic [11:0] phase_a_magnitude;
        logic [11:0] phase_b_magnitude;
        logic [11:0] phase_c_magnitude;
    } clp_phases_type;

    typedef struct packed {
        logic [11:0] low_current_threshold;
        logic [11:0] high_current_threshold;
        logic [11:0] overcurrent_threshold;
        logic [18:0] start_delay_time;
        logic [18:0] maximum_start_time;
        logic [18:0] minimum_hold_time;
    } clp_settings_type;

endpackage

// ==== hdl/clp_sync.sv ====
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
module clp_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Level
    input wire logic din,
    output logic dout
);
    logic stage1;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// ==== hdl/clp_phase_cmp.sv ====
// One threshold comparator with 97 % release above and 103 % release below for a single phase
`timescale 1ns/100ps
module clp_phase_cmp
    import clp_pkg::*;
#(
    parameter bit ABOVE = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Evaluation strobe
    input wire logic tick,
    // Data
    input wire logic [MAG_W-1:0] magnitude,
    input wire logic [MAG_W-1:0] threshold,
    output logic picked
);
    // Cross multiply to compare against 0.97 x threshold exactly
    wire logic [MAG_W+7:0] mag_x100 = 20'(magnitude) * 20'(RESET_DEN);
    wire logic [MAG_W+7:0] thr_x97 = 20'(threshold) * 20'(RESET_NUM);
    wire logic [MAG_W+7:0] thr_x100 = 20'(threshold) * 20'(RESET_DEN);
    wire logic above_pick = magnitude > threshold;
    wire logic above_keep = mag_x100 >= thr_x97;
    wire logic below_pick = magnitude < threshold;
    // Low side releases once magnitude rises above 1.03 x threshold, the mirror of 0.97
    wire logic below_keep = mag_x100 <= thr_x100 + (thr_x100 - thr_x97);
    wire logic next_picked = ABOVE ? (picked ? above_keep : above_pick)
                                   : (picked ? below_keep : below_pick);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            picked <= 1'b0;
        end else if (tick) begin
            picked <= next_picked;
        end
    end
endmodule

// ==== hdl/clp_detector.sv ====
// Cold load pick-up detector: thresholds, timers, blocking and condition
`timescale 1ns/100ps
module clp_detector
    import clp_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Measurements from both sides
    input wire clp_phases_type side1_phases,
    input wire clp_phases_type side2_phases,
    input wire logic sample_valid,
    // Configuration: side latched at reset release, settings read live
    input wire clp_side_type measurement_side,
    input wire clp_settings_type settings,
    // Blocking matrix
    input wire logic block_in,
    // Outputs
    output logic cold_load_active_out,
    output logic blocked_out,
    output function_condition_status_type function_condition_status,
    output logic cycle_tick
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The tick counter is TICK_W bits wide and needs at least two states
    if (TICK_COUNT < 2 || TICK_COUNT >= (1 << TICK_W)) begin : g_bad_tick
        $error("TICK_COUNT out of range");
    end

    // Comparators and timers take their widths from the package constants
    if ($bits(clp_phases_type) != 3 * MAG_W) begin : g_bad_mag
        $error("Phase record width does not match MAG_W");
    end

    if ($bits(clp_settings_type) != 3 * MAG_W + 3 * TIME_W) begin : g_bad_time
        $error("Settings record width does not match MAG_W and TIME_W");
    end

    // ------------------------------------------------------------
    // Processing cycle time base
    // ------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt;
    wire logic tick_wrap = tick_cnt == TICK_W'(TICK_COUNT - 1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_cnt <= '0;
            cycle_tick <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
            cycle_tick <= tick_wrap;
        end
    end

    // ------------------------------------------------------------
    // Input capture
    // ------------------------------------------------------------
    // Side is latched at reset release only, so it stays static
    clp_side_type side_sel;
    logic side_taken;
    clp_phases_type phases;
    logic block_sync;
    logic block_cycle;

    clp_sync u_block_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(block_in),
        .dout(block_sync)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            side_sel <= CLP_SIDE_1;
            side_taken <= 1'b0;
        end else if (!side_taken) begin
            side_sel <= measurement_side;
            side_taken <= 1'b1;
        end
    end

    // Measurements come from logic on this clock
    wire clp_phases_type selected_phases = (side_sel == CLP_SIDE_2) ? side2_phases : side1_phases;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phases <= '0;
        end else if (sample_valid) begin
            phases <= selected_phases;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            block_cycle <= 1'b0;
        end else if (tick_wrap) begin
            block_cycle <= block_sync;
        end
    end

    // ------------------------------------------------------------
    // Per-phase comparisons
    // ------------------------------------------------------------
    // Thresholds are read live each tick, so group changes apply at once
    wire logic [MAG_W-1:0] mags [3];
    assign mags[0] = phases.phase_a_magnitude;
    assign mags[1] = phases.phase_b_magnitude;
    assign mags[2] = phases.phase_c_magnitude;

    logic [2:0] low_pick;
    logic [2:0] high_pick;
    logic [2:0] over_pick;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        clp_phase_cmp #(.ABOVE(1'b0)) u_low (
            .clk_sys(clk_sys),
            .rst(rst),
            .tick(tick_wrap),
            .magnitude(mags[p]),
            .threshold(settings.low_current_threshold),
            .picked(low_pick[p])
        );
        clp_phase_cmp #(.ABOVE(1'b1)) u_high (
            .clk_sys(clk_sys),
            .rst(rst),
            .tick(tick_wrap),
            .magnitude(mags[p]),
            .threshold(settings.high_current_threshold),
            .picked(high_pick[p])
        );
        clp_phase_cmp #(.ABOVE(1'b1)) u_over (
            .clk_sys(clk_sys),
            .rst(rst),
            .tick(tick_wrap),
            .magnitude(mags[p]),
            .threshold(settings.overcurrent_threshold),
            .picked(over_pick[p])
        );
    end

    wire logic all_low = &low_pick;
    wire logic all_high = &high_pick;
    wire logic any_over = |over_pick;

    // ------------------------------------------------------------
    // Timers in processing cycles
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_LOW,
        ST_ACTIVE,
        ST_BLOCKED,
        ST_OVER
    } clp_state_type;

    clp_state_type state;
    logic [TIME_W-1:0] low_time;
    logic [TIME_W-1:0] high_time;
    logic [TIME_W-1:0] hold_time;
    logic eval;

    // Comparators update on tick_wrap, decisions follow one clock later
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eval <= 1'b0;
        end else begin
            eval <= tick_wrap;
        end
    end

    wire logic start_done = low_time >= settings.start_delay_time;
    wire logic max_done = high_time >= settings.maximum_start_time;
    wire logic hold_done = hold_time >= settings.minimum_hold_time;
    // Start-up over: overcurrent, inrush past the maximum start time, or no inrush after the hold
    wire logic release_now = any_over || (all_high ? max_done : hold_done);

    clp_state_type next_state;

    always_comb begin
        next_state = state;
        case (state)
            ST_NORMAL: begin
                if (all_low) begin
                    next_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (!all_low) begin
                    next_state = ST_NORMAL;
                end else if (start_done) begin
                    next_state = block_cycle ? ST_BLOCKED : ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (any_over) begin
                    next_state = ST_OVER;
                end else if (block_cycle) begin
                    next_state = ST_NORMAL;
                end else if (!all_low && release_now) begin
                    next_state = ST_NORMAL;
                end
            end
            ST_BLOCKED: begin
                if (!all_low || !block_cycle) begin
                    next_state = ST_NORMAL;
                end
            end
            ST_OVER: begin
                // A new cold load needs a fresh low-current period
                if (!any_over) begin
                    next_state = ST_NORMAL;
                end
            end
            default: begin
                next_state = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_NORMAL;
        end else if (eval) begin
            state <= next_state;
        end
    end

    // Counters saturate rather than wrap
    wire logic [TIME_W-1:0] time_max = '1;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_time <= '0;
            high_time <= '0;
            hold_time <= '0;
        end else if (eval) begin
            low_time <= (state == ST_LOW && all_low && low_time != time_max) ? low_time + 1'b1
                      : (state == ST_LOW && all_low) ? low_time : TIME_W'(1);
            // Release timers restart from zero on every activation
            if (next_state == ST_ACTIVE && state != ST_ACTIVE) begin
                high_time <= '0;
                hold_time <= '0;
            end else begin
                if (all_high && high_time != time_max) begin
                    high_time <= high_time + 1'b1;
                end
                if (!all_low && hold_time != time_max) begin
                    hold_time <= hold_time + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Condition code is decoded from the next state, so it moves with the state register
    wire logic next_active = next_state == ST_ACTIVE;
    wire logic next_blocked = next_state == ST_BLOCKED;
    function_condition_status_type next_condition;

    always_comb begin
        case (next_state)
            ST_LOW: next_condition = CLP_CURR_LOW;
            ST_ACTIVE: next_condition = CLP_ACTIVE;
            ST_BLOCKED: next_condition = CLP_BLOCKED;
            ST_OVER: next_condition = CLP_OVERCURRENT_ON;
            default: next_condition = CLP_NORMAL;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cold_load_active_out <= 1'b0;
            blocked_out <= 1'b0;
            function_condition_status <= CLP_NORMAL;
        end else if (eval) begin
            cold_load_active_out <= next_active;
            blocked_out <= next_blocked;
            function_condition_status <= next_condition;
        end
    end
endmodule

// ==== verif/clp_detector_props.sv ====
// Concurrent checks on the cold load detector outputs
`timescale 1ns/100ps
module clp_detector_props
    import clp_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Observed outputs
    input wire logic cold_load_active_out,
    input wire logic blocked_out,
    input wire function_condition_status_type function_condition_status,
    input wire logic cycle_tick
);
    // ------------------------------------------------------------
    // Tick spacing helper
    // ------------------------------------------------------------
    int cnt;
    logic seen;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            seen <= 1'b0;
        end else if (cycle_tick) begin
            cnt <= 0;
            seen <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_normal: assert property ($fell(rst) |->
        function_condition_status == CLP_NORMAL && !cold_load_active_out && !blocked_out)
        else $error("outputs not idle after reset");
    a_status_legal: assert property (function_condition_status <= CLP_BLOCKED)
        else $error("condition code out of range");
    a_active_match: assert property (cold_load_active_out == (function_condition_status == CLP_ACTIVE))
        else $error("active output disagrees with condition");
    a_blocked_match: assert property (blocked_out == (function_condition_status == CLP_BLOCKED))
        else $error("blocked output disagrees with condition");
    // Outputs move on the edge after cycle_tick rises
    a_outs_stand: assert property (!$past(cycle_tick) |-> $stable(function_condition_status) &&
        $stable(cold_load_active_out) && $stable(blocked_out))
        else $error("outputs changed inside a processing cycle");
    a_tick_period: assert property (cycle_tick && seen |-> cnt == TICK_COUNT - 1)
        else $error("processing cycle length wrong");
    a_tick_gap: assert property (cnt < TICK_COUNT + 2)
        else $error("processing cycle overdue");
    a_over_entry: assert property (function_condition_status == CLP_OVERCURRENT_ON &&
        $past(function_condition_status) != CLP_OVERCURRENT_ON |->
        $past(function_condition_status) == CLP_ACTIVE && $fell(cold_load_active_out))
        else $error("overcurrent state not entered from active");
    a_active_entry: assert property ($rose(cold_load_active_out) |->
        $past(function_condition_status) == CLP_CURR_LOW)
        else $error("active raised without low current");
    a_blocked_entry: assert property ($rose(blocked_out) |->
        $past(function_condition_status) == CLP_CURR_LOW)
        else $error("blocked raised without low current");
    c_active: cover property ($rose(cold_load_active_out));
    c_blocked: cover property ($rose(blocked_out));
    c_over: cover property (function_condition_status == CLP_OVERCURRENT_ON);
endmodule

// ==== verif/clp_meas_model.sv ====
// Behavioural phase measurement source and blocking matrix
`timescale 1ns/100ps
module clp_meas_model
    import clp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Scenario control
    input wire clp_side_type side_sel,
    input wire clp_phases_type target,
    input wire logic block_req,
    // Far side
    output clp_phases_type side1_phases,
    output clp_phases_type side2_phases,
    output logic sample_valid,
    output logic block_in
);
    // Unselected module shows the inverse, so a wrong pick reads as overcurrent
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            side1_phases <= '0;
            side2_phases <= '1;
            sample_valid <= 1'b0;
            block_in <= 1'b0;
        end else begin
            side1_phases <= (side_sel == CLP_SIDE_1) ? target : ~target;
            side2_phases <= (side_sel == CLP_SIDE_2) ? target : ~target;
            sample_valid <= 1'b1;
            // Changes right after a cycle boundary, long before the next one
            block_in <= block_req;
        end
    end
endmodule

// ==== verif/clp_detector_tb.sv ====
// Self-checking bench for the cold load pick-up detector
`timescale 1ns/100ps
module clp_detector_tb
    import clp_pkg::*;
;
    localparam int TC = 20;
    typedef struct {
        logic [11:0] a, b, c;
        logic blk;
        logic [11:0] low;
        int wt;
        function_condition_status_type st;
    } clp_row_type;
    logic clk_sys, rst, sample_valid, block_in, block_req;
    logic cold_load_active_out, blocked_out, cycle_tick;
    clp_phases_type side1_phases, side2_phases, target;
    clp_side_type measurement_side;
    clp_settings_type settings;
    function_condition_status_type function_condition_status;
    int miscompares, tests_run;
    clp_row_type rows [20] = '{
        '{12'h00a, 12'h00a, 12'h00a, 1'b0, 12'h014, 1, CLP_CURR_LOW},
        '{12'h00a, 12'h00a, 12'h00a, 1'b0, 12'h014, 1, CLP_ACTIVE},
        '{12'h0fa, 12'h064, 12'h064, 1'b0, 12'h014, 1, CLP_OVERCURRENT_ON},
        '{12'h064, 12'h064, 12'h064, 1'b0, 12'h014, 1, CLP_NORMAL},
        '{12'h00a, 12'h00a, 12'h00a, 1'b0, 12'h014, 2, CLP_ACTIVE},
        '{12'h032, 12'h032, 12'h032, 1'b0, 12'h014, 3, CLP_NORMAL},
        '{12'h00a, 12'h00a, 12'h00a, 1'b0, 12'h014, 2, CLP_ACTIVE},
        '{12'h096, 12'h096, 12'h096, 1'b0, 12'h014, 1, CLP_ACTIVE},
        '{12'h096, 12'h096, 12'h096, 1'b0, 12'h014, 5, CLP_NORMAL},
        '{12'h00a, 12'h00a, 12'h00a, 1'b1, 12'h014, 2, CLP_BLOCKED},
        '{12'h00a, 12'h00a, 12'h00a, 1'b0, 12'h014, 3, CLP_ACTIVE},
        '{12'h00a, 12'h00a, 12'h00a, 1'b1, 12'h014, 1, CLP_NORMAL},
        '{12'h00a, 12'h00a, 12'h00a, 1'b1, 12'h014, 2, CLP_BLOCKED},
        '{12'h00a, 12'h00a, 12'h00a, 1'b0, 12'h014, 3, CLP_ACTIVE},
        '{12'h0c9, 12'h00a, 12'h00a, 1'b0, 12'h014, 1, CLP_OVERCURRENT_ON},
        '{12'h0c3, 12'h00a, 12'h00a, 1'b0, 12'h014, 2, CLP_OVERCURRENT_ON},
        '{12'h0c1, 12'h00a, 12'h00a, 1'b0, 12'h014, 1, CLP_NORMAL},
        '{12'h019, 12'h00a, 12'h00a, 1'b0, 12'h014, 2, CLP_NORMAL},
        '{12'h019, 12'h00a, 12'h00a, 1'b0, 12'h01e, 1, CLP_CURR_LOW},
        '{12'h019, 12'h00a, 12'h00a, 1'b0, 12'h01e, 1, CLP_ACTIVE}
    };
    clp_detector #(.TICK_COUNT(TC)) clp_detector_i (
        .clk_sys(clk_sys), .rst(rst), .side1_phases(side1_phases), .side2_phases(side2_phases),
        .sample_valid(sample_valid), .measurement_side(measurement_side), .settings(settings),
        .block_in(block_in), .cold_load_active_out(cold_load_active_out), .blocked_out(blocked_out),
        .function_condition_status(function_condition_status), .cycle_tick(cycle_tick));
    clp_meas_model clp_meas_model_i (
        .clk_sys(clk_sys), .rst(rst), .side_sel(measurement_side), .target(target),
        .block_req(block_req), .side1_phases(side1_phases), .side2_phases(side2_phases),
        .sample_valid(sample_valid), .block_in(block_in));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk_st(input string name, input int row, input logic [2:0] exp, input logic [2:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s row %0d expected %0d seen %0d", name, row, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input int row, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s row %0d expected %b seen %b", name, row, exp, got);
        end
    endtask
    // Returns one edge after the output update edge, so updated outputs are read
    task automatic wait_ticks(input int n);
        int guard;
        guard = 0;
        repeat (n) begin
            @(posedge clk_sys);
            while (cycle_tick !== 1'b1 && guard < 1000) begin
                @(posedge clk_sys);
                guard++;
            end
        end
        @(posedge clk_sys);
        if (guard >= 1000) begin
            miscompares++;
            $display("[FAIL] cycle_tick expected 1 seen %b", cycle_tick);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end
    initial begin
        miscompares = 0;
        tests_run = 0;
        rst = 1'b1;
        block_req = 1'b0;
        measurement_side = CLP_SIDE_1;
        target = '{12'h064, 12'h064, 12'h064};
        settings = '{LOW_DEFAULT, HIGH_DEFAULT, OVER_DEFAULT, 19'h00001, 19'h00004, 19'h00002};
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        wait_ticks(1);
        foreach (rows[i]) begin
            target <= '{rows[i].a, rows[i].b, rows[i].c};
            block_req <= rows[i].blk;
            settings.low_current_threshold <= rows[i].low;
            wait_ticks(rows[i].wt);
            chk_st("status", i, rows[i].st, function_condition_status);
            chk_bit("active", i, rows[i].st == CLP_ACTIVE, cold_load_active_out);
            chk_bit("blocked", i, rows[i].st == CLP_BLOCKED, blocked_out);
        end
        // Mid-run reset onto the second measurement module
        rst <= 1'b1;
        measurement_side <= CLP_SIDE_2;
        repeat (2) @(posedge clk_sys);
        chk_st("reset status", 90, CLP_NORMAL, function_condition_status);
        chk_bit("reset active", 90, 1'b0, cold_load_active_out);
        rst <= 1'b0;
        wait_ticks(3);
        chk_st("side two", 91, CLP_ACTIVE, function_condition_status);
        // Short block pulse between cycle boundaries must be missed
        block_req <= 1'b1;
        repeat (3) @(posedge clk_sys);
        block_req <= 1'b0;
        wait_ticks(1);
        chk_st("block pulse", 92, CLP_ACTIVE, function_condition_status);
        end_of_test();
    end
endmodule
bind clp_detector clp_detector_props #(.TICK_COUNT(TICK_COUNT)) clp_detector_props_i (
    .clk_sys(clk_sys), .rst(rst), .cold_load_active_out(cold_load_active_out), .blocked_out(blocked_out),
    .function_condition_status(function_condition_status), .cycle_tick(cycle_tick));
